//--- dv/fcs_chk.sv
`timescale 1ns/1ps
// ====
// port checker
module fcs_chk (
    // clock and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // control and enables
    input wire logic stop_req,
    input wire logic low_power,
    input wire logic system_clock_out,
    input wire logic bus_clock_en,
    input wire logic debug_controller_clock,
    input wire logic loop_enable,
    input wire logic [8:0] trim_out
);
    logic [7:0] c1_q;
    logic [3:0] qt_q;
    logic lpb;
    logic c1w;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // shadow of control one; qt_q counts quiet cycles after a write
    always_ff @(posedge clk) begin
        if (rst) begin
            c1_q <= fcs_pkg::CTRL1_RESET;
            qt_q <= 4'hf;
        end else if (c1w) begin
            c1_q <= wdata;
            qt_q <= 4'h0;
        end else if (qt_q != 4'hf) begin
            qt_q <= qt_q + 4'h1;
        end
    end
    // low power bypass only with a reference source, code 11 acts as loop
    assign c1w = wr && addr == 2'h0;
    assign lpb = low_power && (c1_q[7] ^ c1_q[6]);
    property p_rd1; rd && addr == 2'h0 |=> rdata == (c1_q | 8'h06); endproperty
    a_rd1: assert property (p_rd1) else $error("control read");
    property p_rst; $fell(rst) |-> loop_enable && trim_out == 9'h100; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_bus; bus_clock_en |-> $past(system_clock_out); endproperty
    a_bus: assert property (p_bus) else $error("bus tick alone");
    property p_stop;
        stop_req [*6] |-> !(system_clock_out || bus_clock_en || loop_enable);
    endproperty
    a_stop: assert property (p_stop) else $error("stop clocks");
    property p_lpl; lpb [*8] |-> !loop_enable; endproperty
    a_lpl: assert property (p_lpl) else $error("loop on");
    property p_lpd; lpb [*8] |=> $stable(debug_controller_clock); endproperty
    a_lpd: assert property (p_lpd) else $error("debug runs");
    property p_eng; (!lpb && !stop_req) [*8] |-> loop_enable; endproperty
    a_eng: assert property (p_eng) else $error("loop off");
    property p_st;
        rd && addr == 2'h3 && qt_q == 4'hf
            |=> rdata[3:2] == (lpb | c1_q[7] ^ c1_q[6] ? c1_q[7:6] : 2'h0);
    endproperty
    a_st: assert property (p_st) else $error("status");
    property p_lag;
        c1w && wdata[7:6] == 2'h1 && c1_q[7:6] == 2'h0 && qt_q == 4'hf ##1 rd && addr == 2'h3
            |=> rdata[3:2] == 2'h0;
    endproperty
    a_lag: assert property (p_lag) else $error("status early");
    c_lp: cover property (lpb [*8]);
    c_stop: cover property (stop_req [*6]);
    c_lag: cover property (c1w ##1 rd && addr == 2'h3);
endmodule : fcs_chk
bind fcs_clock_unit fcs_chk u_fcs_chk (.*);

//--- dv/fcs_src_model.sv
`timescale 1ns/1ps
// ====
// source clocks, free running, unrelated in phase to clk
module fcs_src_model (
    // oscillator and references
    output logic loop_osc_tick = 1'h0,
    output logic int_ref_tick = 1'h0,
    output logic ext_ref_tick = 1'h0
);
    // references stay far below 5 MHz so every edge is sampled
    always #61.3 loop_osc_tick = ~loop_osc_tick;
    always #311 int_ref_tick = ~int_ref_tick;
    always #207 ext_ref_tick = ~ext_ref_tick;
endmodule : fcs_src_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
// ====
// bench: register model, modes, divider, stop
module tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic stop_req = 1'h0;
    logic low_power = 1'h0;
    logic loop_osc_tick, int_ref_tick, ext_ref_tick, system_clock_out, bus_clock_en;
    logic debug_controller_clock, int_ref_clock_out, loop_ref_tick, loop_enable;
    logic [7:0] rdata, d;
    logic [8:0] trim_out;
    int errors = 0;
    int checked = 0;
    int seed = 92;
    int n_sys = 0;
    int n_bus = 0;
    int n_dbg = 0;
    int n_osc = 0;
    int n_ir = 0;
    int n_irc = 0;
    int n_lrf = 0;
    int s0, b0, g0, e, o0, i0, l0, r0;
    int mdl[4];
    always #12.5 clk = ~clk;
    fcs_clock_unit u_fcs_clock_unit (.*);
    fcs_src_model u_fcs_src_model (.*);
    // tick counters for rate checks
    always @(posedge clk) begin
        n_sys <= n_sys + int'(system_clock_out);
        n_bus <= n_bus + int'(bus_clock_en);
        n_irc <= n_irc + int'(int_ref_clock_out);
        n_lrf <= n_lrf + int'(loop_ref_tick);
    end
    always @(debug_controller_clock) n_dbg++;
    // source edges counted at the pins, the reference for divider checks
    always @(posedge loop_osc_tick) n_osc++;
    always @(posedge int_ref_tick) n_ir++;
    task automatic check(input string s, input logic [8:0] v, input logic [8:0] x);
        checked++;
        if (v !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, x, v);
        end
    endtask : check
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        mdl[a] = (a == 2'h0) ? int'(v | fcs_pkg::CTRL1_FORCE_ONE) : int'(v);
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg
    // status bit 1 reads zero in the design, masked and not modelled
    task automatic rd_chk(input logic [1:0] a);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        check("rdata", {1'h0, rdata & ~{6'h00, a == 2'h3, 1'h0}}, 9'(mdl[a]));
        @(posedge clk);
    endtask : rd_chk
    task automatic do_reset();
        rst <= 1'h1;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        mdl = '{int'(fcs_pkg::CTRL1_RESET | fcs_pkg::CTRL1_FORCE_ONE),
            int'(fcs_pkg::CTRL2_RESET), int'(fcs_pkg::TRIM_RESET), 0};
    endtask : do_reset
    task automatic give_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        do_reset();
        for (int a = 0; a < 4; a++) rd_chk(2'(a));
        // every source code, low power off and on, random other fields
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d[7:6] = 2'(i);
            low_power <= i[2];
            wr_reg(2'h0, d);
            rd_chk(2'h3);
            mdl[3] = (d[7] ^ d[6]) ? int'(d[7:6]) * 4 : 0;
            repeat (40) @(posedge clk);
            s0 = n_sys;
            g0 = n_dbg;
            r0 = n_irc;
            repeat (400) @(posedge clk);
            rd_chk(2'h0);
            rd_chk(2'h3);
            check("loop", 9'(loop_enable), 9'(!(i[2] && (i[1] ^ i[0]))));
            check("dbg", 9'(n_dbg > g0), 9'(!(i[2] && (i[1] ^ i[0]))));
            check("sys", 9'(n_sys > s0), 9'h001);
            check("iref", 9'(n_irc > r0), 9'(d[1]));
        end
        // bus and reference divider codes with the loop engaged
        low_power <= 1'h0;
        for (int b = 0; b < 4; b++) begin
            wr_reg(2'h0, {2'h0, 3'(b), 3'h4});
            wr_reg(2'h1, {2'(b), 6'h00});
            rd_chk(2'h1);
            repeat (20) @(posedge clk);
            s0 = n_sys;
            b0 = n_bus;
            o0 = n_osc;
            g0 = n_dbg;
            i0 = n_ir;
            l0 = n_lrf;
            repeat (2000) @(posedge clk);
            // counts may differ by two from window edges and sync delay
            e = ((n_osc - o0) >> b) - (n_sys - s0) + 2;
            check("sys div", 9'(e >= 0 && e <= 4), 9'h001);
            e = ((n_sys - s0) >> 1) - (n_bus - b0) + 2;
            check("bus", 9'(e >= 0 && e <= 4), 9'h001);
            e = (n_osc - o0) - (n_dbg - g0) + 2;
            check("dbg div", 9'(e >= 0 && e <= 4), 9'h001);
            e = ((n_ir - i0) >> b) - (n_lrf - l0) + 2;
            check("ref div", 9'(e >= 0 && e <= 4), 9'h001);
        end
        // stop with the internal reference dropped, then kept
        for (int k = 0; k < 2; k++) begin
            wr_reg(2'h0, 8'h06 | 8'(k));
            stop_req <= 1'h1;
            repeat (10) @(posedge clk);
            s0 = n_sys;
            r0 = n_irc;
            l0 = n_lrf;
            repeat (200) @(posedge clk);
            check("stop", 9'(n_sys - s0), 9'h000);
            check("lref", 9'(n_lrf - l0), 9'h000);
            check("iref", 9'(n_irc > r0), 9'(k));
            stop_req <= 1'h0;
        end
        d = 8'($random(seed));
        wr_reg(2'h2, d);
        rd_chk(2'h2);
        check("trim", trim_out, {d, 1'h0});
        do_reset();
        rd_chk(2'h0);
        rd_chk(2'h1);
        give_verdict();
    end
    // watchdog, run takes about 12100 cycles
    initial begin
        #1ms;
        errors++;
        give_verdict();
    end
endmodule : tb_top

//--- hw/fcs_clock_unit.sv
`timescale 1ns/1ps
// internal clock unit: clock enables stand in for the generated clocks
module fcs_clock_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // system control
    input wire logic stop_req,
    input wire logic low_power,
    input wire logic loop_osc_tick,
    input wire logic int_ref_tick,
    input wire logic ext_ref_tick,
    // clock enables out
    output logic system_clock_out,
    output logic bus_clock_en,
    output logic debug_controller_clock,
    output logic int_ref_clock_out,
    output logic loop_ref_tick,
    output logic loop_enable,
    output logic [8:0] trim_out
);
    // ==========================================
    // registers
    fcs_pkg::fcs_ctrl1_t c1_q;
    logic [7:0] c2_q, trim_q, rdata_q;
    logic fine_trim_q;
    logic [1:0] status_q, sync1_q, sync2_q, cur_src_q;
    logic stop1_q, stop2_q, lp1_q, lp2_q;
    logic [2:0] osc_s_q, int_s_q, ext_s_q;
    logic [6:0] refdiv_cnt_q;
    logic [2:0] busdiv_cnt_q, bus_mask;
    logic dbg_q, sys_q, bus_q, bus_ph_q, iref_q, lref_q, lena_q;
    logic src_edge;
    logic was_int_q;
    fcs_pkg::fcs_mode_t mode_q;

    // reserved source code behaves like loop output
    function automatic logic [1:0] src_of(input logic [1:0] c);
        src_of = (c == 2'h3) ? fcs_pkg::SRC_LOOP : c;
    endfunction : src_of

    function automatic logic rise(input logic [2:0] s);
        rise = s[1] & ~s[2];
    endfunction : rise

    // ==========================================
    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            c1_q <= fcs_pkg::CTRL1_RESET;
            c2_q <= fcs_pkg::CTRL2_RESET;
            trim_q <= fcs_pkg::TRIM_RESET;
            fine_trim_q <= 1'b0;
        end else if (wr) begin
            case (addr)
                fcs_pkg::ADDR_CTRL1: c1_q <= fcs_pkg::fcs_ctrl1_t'(wdata);
                fcs_pkg::ADDR_CTRL2: c2_q <= wdata;
                fcs_pkg::ADDR_TRIM: trim_q <= wdata;
                default: fine_trim_q <= wdata[0];
            endcase
        end
    end
    assign trim_out = {trim_q, fine_trim_q};

    // read data one cycle after strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                fcs_pkg::ADDR_CTRL1: rdata_q <= c1_q | fcs_pkg::CTRL1_FORCE_ONE;
                fcs_pkg::ADDR_CTRL2: rdata_q <= c2_q;
                fcs_pkg::ADDR_TRIM: rdata_q <= trim_q;
                default: rdata_q <= {4'h0, status_q, 1'b0, fine_trim_q};
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;

    // ==========================================
    // input synchronisers; oscillator ticks are slow relative to clk
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_s_q <= 3'h0;
            int_s_q <= 3'h0;
            ext_s_q <= 3'h0;
            stop1_q <= 1'b0;
            stop2_q <= 1'b0;
            lp1_q <= 1'b0;
            lp2_q <= 1'b0;
        end else begin
            osc_s_q <= {osc_s_q[1:0], loop_osc_tick};
            int_s_q <= {int_s_q[1:0], int_ref_tick};
            ext_s_q <= {ext_s_q[1:0], ext_ref_tick};
            stop1_q <= stop_req;
            stop2_q <= stop1_q;
            lp1_q <= low_power;
            lp2_q <= lp1_q;
        end
    end

    // ==========================================
    // mode decode from source, reference select and low power
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= fcs_pkg::M_ENG_INT;
            was_int_q <= 1'b1;
        end else if (stop2_q) begin
            mode_q <= fcs_pkg::M_STOP;
        end else begin
            was_int_q <= c1_q.loop_ref_internal_sel;
            case (cur_src_q)
                fcs_pkg::SRC_INT: mode_q <= lp2_q ? fcs_pkg::M_BYP_INT_LP : fcs_pkg::M_BYP_INT;
                fcs_pkg::SRC_EXT: mode_q <= lp2_q ? fcs_pkg::M_BYP_EXT_LP : fcs_pkg::M_BYP_EXT;
                default: mode_q <= c1_q.loop_ref_internal_sel ? fcs_pkg::M_ENG_INT
                                                               : fcs_pkg::M_ENG_EXT;
            endcase
        end
    end

    // loop runs unless stopped or in a low power bypass
    always_ff @(posedge clk) begin
        if (rst) begin
            lena_q <= 1'b1;
        end else begin
            case (mode_q)
                fcs_pkg::M_BYP_INT_LP, fcs_pkg::M_BYP_EXT_LP: lena_q <= 1'b0;
                fcs_pkg::M_STOP: lena_q <= 1'b0;
                default: lena_q <= 1'b1;
            endcase
        end
    end
    assign loop_enable = lena_q;

    // ==========================================
    // glitch-free switch: change source only in a cycle with no system clock pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_src_q <= fcs_pkg::SRC_LOOP;
            sync1_q <= fcs_pkg::SRC_LOOP;
            sync2_q <= fcs_pkg::SRC_LOOP;
            status_q <= fcs_pkg::SRC_LOOP;
        end else begin
            sync1_q <= src_of(c1_q.clock_source_sel);
            sync2_q <= sync1_q;
            if (sync2_q != cur_src_q && !sys_q) begin
                cur_src_q <= sync2_q;
            end
            status_q <= cur_src_q;
        end
    end

    // rising edge of whichever source the switch has settled on
    always_comb begin
        case (cur_src_q)
            fcs_pkg::SRC_INT: src_edge = rise(int_s_q);
            fcs_pkg::SRC_EXT: src_edge = rise(ext_s_q);
            default: src_edge = rise(osc_s_q) & lena_q;
        endcase
    end

    // divide mask; code 3 wraps the 3-bit shift to zero, giving all ones
    assign bus_mask = (3'h1 << c2_q[fcs_pkg::BUS_DIV_LSB +: 2]) - 3'h1;

    // system clock: selected source divided by 1, 2, 4 or 8
    always_ff @(posedge clk) begin
        if (rst) begin
            busdiv_cnt_q <= 3'h0;
            sys_q <= 1'b0;
        end else if (mode_q == fcs_pkg::M_STOP) begin
            sys_q <= 1'b0;
        end else begin
            sys_q <= 1'b0;
            if (src_edge) begin
                busdiv_cnt_q <= busdiv_cnt_q + 3'h1;
                sys_q <= (busdiv_cnt_q & bus_mask) == 3'h0;
            end
        end
    end
    assign system_clock_out = sys_q;

    // bus clock: every second system tick, one cycle behind it
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_ph_q <= 1'b0;
            bus_q <= 1'b0;
        end else begin
            bus_q <= sys_q & bus_ph_q;
            if (sys_q) begin
                bus_ph_q <= ~bus_ph_q;
            end
        end
    end
    assign bus_clock_en = bus_q;

    // debug clock: oscillator divided by two while loop on
    always_ff @(posedge clk) begin
        if (rst) begin
            dbg_q <= 1'b0;
        end else if (rise(osc_s_q) && lena_q) begin
            dbg_q <= ~dbg_q;
        end else if (!lena_q) begin
            dbg_q <= 1'b0;
        end
    end
    assign debug_controller_clock = dbg_q;

    // internal reference output gated and kept in stop
    always_ff @(posedge clk) begin
        if (rst) begin
            iref_q <= 1'b0;
        end else if (mode_q == fcs_pkg::M_STOP) begin
            iref_q <= c1_q.int_ref_stop_keep & (c1_q.int_ref_output_enable | was_int_q)
                      & rise(int_s_q);
        end else begin
            iref_q <= c1_q.int_ref_output_enable & rise(int_s_q);
        end
    end
    assign int_ref_clock_out = iref_q;

    // reference divider for the loop, pulse every 2^code reference edges
    always_ff @(posedge clk) begin
        if (rst) begin
            refdiv_cnt_q <= 7'h00;
            lref_q <= 1'b0;
        end else begin
            lref_q <= 1'b0;
            // code 7 wraps the 7-bit shift, so the mask becomes all ones
            if (c1_q.loop_ref_internal_sel ? rise(int_s_q) : rise(ext_s_q)) begin
                refdiv_cnt_q <= refdiv_cnt_q + 7'h01;
                lref_q <= ((refdiv_cnt_q & ((7'h01 << c1_q.reference_divider_sel) - 7'h01))
                           == 7'h00) & lena_q;
            end
        end
    end
    assign loop_ref_tick = lref_q;
endmodule : fcs_clock_unit

//--- hw/fcs_pkg.sv
// Notes on behaviour
// - system clock runs at twice bus clock
// - control bits 1 and 2 read one
// - two-bit bus divider: 1, 2, 4, 8
// - debug clock is oscillator divided by two
// - reset enters internal engaged loop mode
// - internal engaged: loop clock, debug clock on
// - external engaged: loop clock, debug clock on
// - internal bypass: loop on, internal reference out
// - internal low power: loop off, no debug
// - external bypass: loop on, external reference out
// - external low power: loop off, no debug
// - stop: no clocks, references per stop enable
// - clock source field 7:6, code 11 acts 00
// - reference divider 5:3, two to the code
// - bit 2 picks internal loop reference
// - bit 1 gates internal reference output
// - bit 0 keeps internal reference in stop
// - references up to 5 MHz accepted
// - internal reference has nine trim bits
// - bus divider resets to divide by two
// - mode status follows source after synchronisation
package fcs_pkg;
    // ==========================================
    // register map
    localparam logic [1:0] ADDR_CTRL1 = 2'h0;
    localparam logic [1:0] ADDR_CTRL2 = 2'h1;
    localparam logic [1:0] ADDR_TRIM = 2'h2;
    localparam logic [1:0] ADDR_STAT = 2'h3;
    localparam logic [7:0] CTRL1_RESET = 8'h04;
    localparam logic [7:0] CTRL2_RESET = 8'h40;
    localparam logic [7:0] TRIM_RESET = 8'h80;
    localparam logic [7:0] CTRL1_FORCE_ONE = 8'h06;
    // lowest bit of the two-bit bus divider field in control two
    localparam int BUS_DIV_LSB = 6;
    // ==========================================
    // field codes
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_INT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam int REF_MAX_KHZ = 5000;
    localparam int TRIM_BITS = 9;
    typedef struct packed {
        logic [1:0] clock_source_sel;
        logic [2:0] reference_divider_sel;
        logic loop_ref_internal_sel;
        logic int_ref_output_enable;
        logic int_ref_stop_keep;
    } fcs_ctrl1_t;
    typedef enum logic [2:0] {
        M_ENG_INT, M_ENG_EXT, M_BYP_INT, M_BYP_INT_LP, M_BYP_EXT, M_BYP_EXT_LP, M_STOP
    } fcs_mode_t;
endpackage : fcs_pkg
